//--- rtl/hrp_pkg.sv
// How it works
// RULE1 - Power cut output low turns regulator off; wake releases it to restore power.
// RULE2 - While asleep, wake pin or armed counter match requests power back.
// RULE3 - Software spaces successive writes, and write then read, by a settling gap.
// RULE4 - Crystal path divides the 4.194304 MHz input by 128 to 32.768 kHz.
// RULE5 - Slow clock source runs only while its enable bit is set.
// RULE6 - Select bit 0 picks crystal divide path, 1 picks direct oscillator.
// RULE7 - After enabling a crystal, software waits its settling time before access.
// RULE8 - With detection enabled, low battery sets its raw status flag.
// RULE9 - With abort also set, a sleep request during low battery is refused.
// RULE10 - Battery level is never evaluated while hibernated.
// RULE11 - Predivider counts slow ticks to one per second; each increments 32-bit counter.
// RULE12 - Trim value divides one second in every 64; others use nominal 0x7FFF.
// RULE13 - Trim above 0x7FFF slows the counter, below speeds it.
// RULE14 - Two 32-bit match values compare continuously; match wakes or raises event.
// RULE15 - Counter counts only when enabled; a load replaces its value any time.
// RULE16 - 64 retained 32-bit words, readable and writable, kept through hibernation.
// RULE17 - Sleep request bit starts power cut; a wake source must be armed first.
// RULE18 - Pin wake enable arms wake pin, match wake enable arms match; both allowed.
// RULE19 - After wake, raw status still shows the pending wake condition.
// RULE20 - Wake, match and low battery events are ORed into one interrupt.
// RULE21 - Raw status shows all events; mask selects interrupt; masked status shows those.
// RULE22 - Writing one to a clear bit clears that pending event.
// RULE23 - Clock select sits at bit 2 of the main control word.
// RULE24 - Match event mask bits sit at bits 1 and 0, one per comparator.
// RULE25 - Raw flags stay set until cleared; masked bit is raw AND mask.
// RULE26 - Control crossing is safe and counter value reads back without tearing.
package hrp_pkg;
    // Main control word fields
    localparam int CTL_W          = 8;
    localparam int CTL_COUNT_EN   = 0;
    localparam int CTL_SLEEP_REQ  = 1;
    localparam int CTL_CLK_SEL    = 2;
    localparam int CTL_MATCH_WAKE = 3;
    localparam int CTL_PIN_WAKE   = 4;
    localparam int CTL_FLAG_A_DET = 5;
    localparam int CTL_CLK_EN     = 6;
    localparam int CTL_FLAG_A_ABT = 7;
    localparam logic [CTL_W-1:0] CTL_RESET = 8'h00;
    // Event bit positions
    localparam int EV_W      = 4;
    localparam int EV_MATCH0 = 0;
    localparam int EV_MATCH1 = 1;
    localparam int EV_FLAG_A = 2;
    localparam int EV_WAKE   = 3;
    // Counter and predivider
    localparam int                 WORD_W       = 32;
    localparam int                 TRIM_W       = 16;
    localparam logic [TRIM_W-1:0]  TRIM_NOMINAL = 16'h7FFF;
    localparam int                 TRIM_LOG2    = 6;
    localparam int                 XTAL_DIV     = 128;
    localparam int                 MEM_WORDS    = 64;
    localparam logic [WORD_W-1:0]  MATCH_RESET  = 32'hFFFFFFFF;
    localparam logic [WORD_W-1:0]  COUNT_RESET  = 32'h00000000;
    // Synchroniser lanes
    localparam int SY_N      = 4;
    localparam int SY_XTAL   = 0;
    localparam int SY_OSC    = 1;
    localparam int SY_WAKE_N = 2;
    localparam int SY_BATLOW = 3;
    localparam logic [SY_N-1:0] SY_RESET = 4'h4;

    typedef enum logic {
        HRP_RUN,
        HRP_SLEEP
    } hrp_state_t;
endpackage

//--- rtl/hrp_top.sv
`timescale 1ns/1ps
module hrp_top #(
    parameter int XTAL_DIV  = hrp_pkg::XTAL_DIV,
    parameter int MEM_WORDS = hrp_pkg::MEM_WORDS
) (
    // Clock, reset, enable
    input  wire logic                           ref_clk,
    input  wire logic                           resetn,
    input  wire logic                           clk_en,
    // Slow clock pins
    input  wire logic                           xtal_in,
    input  wire logic                           osc_in,
    // Wake pin and battery comparator
    input  wire logic                           wake_n,
    input  wire logic                           battery_low,
    // Control
    input  wire logic [hrp_pkg::CTL_W-1:0]      main_control,
    input  wire logic [hrp_pkg::TRIM_W-1:0]     predivider_trim,
    input  wire logic [hrp_pkg::WORD_W-1:0]     match_value_0,
    input  wire logic [hrp_pkg::WORD_W-1:0]     match_value_1,
    input  wire logic [hrp_pkg::WORD_W-1:0]     counter_load,
    input  wire logic                           counter_load_write,
    input  wire logic [hrp_pkg::EV_W-1:0]       event_mask,
    input  wire logic [hrp_pkg::EV_W-1:0]       event_clear,
    // Retained memory
    input  wire logic                           mem_write,
    input  wire logic [$clog2(MEM_WORDS)-1:0]   mem_addr,
    input  wire logic [hrp_pkg::WORD_W-1:0]     mem_wdata,
    output logic      [hrp_pkg::WORD_W-1:0]     retained_words,
    // Status
    output logic      [hrp_pkg::WORD_W-1:0]     counter_value,
    output logic      [hrp_pkg::EV_W-1:0]       raw_event_status,
    output logic      [hrp_pkg::EV_W-1:0]       masked_event_status,
    output logic                                irq,
    output logic                                hibernated,
    output logic                                sleep_refused,
    // Regulator enable
    output logic                                power_cut_n
);
    generate
        if (XTAL_DIV < 2 || (XTAL_DIV & (XTAL_DIV - 1)) != 0) begin : g_bad_div
            $error("XTAL_DIV must be a power of two of at least 2");
        end
        if (MEM_WORDS < 2) begin : g_bad_mem
            $error("MEM_WORDS must be at least 2");
        end
    endgenerate

    localparam int DIV_W = $clog2(XTAL_DIV);

    // Rising edge between the last two samples of a level
    function automatic logic rise(input logic now_v, input logic was_v);
        return now_v & ~was_v;
    endfunction

    // Reset release
    logic [1:0] rst_q;
    logic       rst_n;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    // Control fields
    logic counter_enable;
    logic sleep_request;
    logic slow_clk_select;
    logic match_wake_enable;
    logic pin_wake_enable;
    logic flag_a_detect_enable;
    logic slow_clk_enable;
    logic flag_a_abort_enable;
    assign counter_enable       = main_control[hrp_pkg::CTL_COUNT_EN];
    assign sleep_request        = main_control[hrp_pkg::CTL_SLEEP_REQ];
    assign slow_clk_select      = main_control[hrp_pkg::CTL_CLK_SEL];    // [RULE23]
    assign match_wake_enable    = main_control[hrp_pkg::CTL_MATCH_WAKE];
    assign pin_wake_enable      = main_control[hrp_pkg::CTL_PIN_WAKE];
    assign flag_a_detect_enable = main_control[hrp_pkg::CTL_FLAG_A_DET];
    assign slow_clk_enable      = main_control[hrp_pkg::CTL_CLK_EN];
    assign flag_a_abort_enable  = main_control[hrp_pkg::CTL_FLAG_A_ABT];

    // Pin synchronisers; edge detect reads only the second and third stages
    logic [hrp_pkg::SY_N-1:0] sy1;
    logic [hrp_pkg::SY_N-1:0] sy2;
    logic [hrp_pkg::SY_N-1:0] sy3;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sy1 <= hrp_pkg::SY_RESET;
            sy2 <= hrp_pkg::SY_RESET;
            sy3 <= hrp_pkg::SY_RESET;
        end else if (clk_en) begin
            sy1[hrp_pkg::SY_XTAL]   <= xtal_in;
            sy1[hrp_pkg::SY_OSC]    <= osc_in;
            sy1[hrp_pkg::SY_WAKE_N] <= wake_n;
            sy1[hrp_pkg::SY_BATLOW] <= battery_low;
            sy2 <= sy1;
            sy3 <= sy2;
        end
    end

    logic xtal_rise;
    logic osc_rise;
    logic wake_pin;
    logic bat_low;
    logic wake_pin_q;
    assign xtal_rise  = rise(sy2[hrp_pkg::SY_XTAL], sy3[hrp_pkg::SY_XTAL]);
    assign osc_rise   = rise(sy2[hrp_pkg::SY_OSC], sy3[hrp_pkg::SY_OSC]);
    assign wake_pin   = ~sy2[hrp_pkg::SY_WAKE_N];
    assign wake_pin_q = ~sy3[hrp_pkg::SY_WAKE_N];
    assign bat_low    = sy2[hrp_pkg::SY_BATLOW];

    // Slow tick source
    // Crystal path counts synced input edges
    logic [DIV_W-1:0] xtal_div;
    logic             slow_tick;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            xtal_div <= '0;
        end else if (clk_en) begin
            if (!slow_clk_enable || slow_clk_select) begin               // [RULE5]
                xtal_div <= '0;
            end else if (xtal_rise) begin
                xtal_div <= xtal_div + DIV_W'(1);                        // [RULE4]
            end
        end
    end

    always_comb begin
        slow_tick = 1'b0;
        if (slow_clk_enable) begin                                       // [RULE5]
            if (slow_clk_select) begin
                slow_tick = osc_rise;                                    // [RULE6]
            end else begin
                slow_tick = xtal_rise && (xtal_div == DIV_W'(XTAL_DIV - 1)); // [RULE4] [RULE6]
            end
        end
    end

    // Predivider and seconds counter
    logic [hrp_pkg::TRIM_W-1:0]    prediv;
    logic [hrp_pkg::TRIM_LOG2-1:0] sec_idx;
    logic [hrp_pkg::WORD_W-1:0]    rtc;
    logic                          sec_tick;
    logic [hrp_pkg::TRIM_W-1:0]    next_divisor;
    assign sec_tick = counter_enable && slow_tick && (prediv == '0);     // [RULE11] [RULE15]

    always_comb begin
        if (sec_idx == '1) begin
            next_divisor = predivider_trim;                              // [RULE12] [RULE13]
        end else begin
            next_divisor = hrp_pkg::TRIM_NOMINAL;                        // [RULE12]
        end
    end

    // Divisor N spans N+1 slow ticks
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prediv  <= hrp_pkg::TRIM_NOMINAL;
            sec_idx <= '0;
        end else if (clk_en && counter_enable && slow_tick) begin
            if (prediv == '0) begin
                prediv  <= next_divisor;                                 // [RULE11]
                sec_idx <= sec_idx + hrp_pkg::TRIM_LOG2'(1);
            end else begin
                prediv <= prediv - hrp_pkg::TRIM_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rtc <= hrp_pkg::COUNT_RESET;
        end else if (clk_en) begin
            if (counter_load_write) begin
                rtc <= counter_load;                                     // [RULE15]
            end else if (sec_tick) begin
                rtc <= rtc + hrp_pkg::WORD_W'(1);                        // [RULE11]
            end
        end
    end

    // Whole-word snapshot so a reader never sees a half-updated count
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_value <= hrp_pkg::COUNT_RESET;
        end else if (clk_en) begin
            counter_value <= rtc;                                        // [RULE26]
        end
    end

    // Match comparators
    logic [1:0] match_eq;
    logic [1:0] match_eq_q;
    logic [1:0] match_hit;
    logic [hrp_pkg::WORD_W-1:0] match_ref [2];
    assign match_ref[0] = match_value_0;
    assign match_ref[1] = match_value_1;
    for (genvar m = 0; m < 2; m++) begin : g_match
        assign match_eq[m]  = (rtc == match_ref[m]);                     // [RULE14]
        assign match_hit[m] = rise(match_eq[m], match_eq_q[m]);
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            match_eq_q <= 2'h0;
        end else if (clk_en) begin
            match_eq_q <= match_eq;
        end
    end

    // Hibernation sequencer
    // A request while asleep is ignored
    hrp_pkg::hrp_state_t state;
    logic                sleep_req_q;
    logic                sleep_start;
    logic                flag_a_now;
    logic                wake_now;
    assign sleep_start = rise(sleep_request, sleep_req_q);               // [RULE17]
    assign flag_a_now  = flag_a_detect_enable && bat_low && (state == hrp_pkg::HRP_RUN); // [RULE8] [RULE10]
    assign wake_now    = (pin_wake_enable && wake_pin)                   // [RULE2] [RULE18]
                       || (match_wake_enable && (|match_eq));            // [RULE2] [RULE18]

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state         <= hrp_pkg::HRP_RUN;
            sleep_req_q   <= 1'b0;
            sleep_refused <= 1'b0;
            power_cut_n   <= 1'b1;
            hibernated    <= 1'b0;
        end else if (clk_en) begin
            sleep_req_q   <= sleep_request;
            sleep_refused <= 1'b0;
            case (state)
                hrp_pkg::HRP_RUN: begin
                    if (sleep_start) begin
                        if ((flag_a_abort_enable && flag_a_now)          // [RULE9]
                            || !(pin_wake_enable || match_wake_enable)) begin // [RULE17]
                            sleep_refused <= 1'b1;
                        end else begin
                            state       <= hrp_pkg::HRP_SLEEP;
                            power_cut_n <= 1'b0;                         // [RULE1]
                            hibernated  <= 1'b1;
                        end
                    end
                end
                hrp_pkg::HRP_SLEEP: begin
                    if (wake_now) begin
                        state       <= hrp_pkg::HRP_RUN;
                        power_cut_n <= 1'b1;                             // [RULE1] [RULE2]
                        hibernated  <= 1'b0;
                    end
                end
                default: begin
                    state       <= hrp_pkg::HRP_RUN;
                    power_cut_n <= 1'b1;
                    hibernated  <= 1'b0;
                end
            endcase
        end
    end

    // Event flags: set beats clear in the same cycle
    logic [hrp_pkg::EV_W-1:0] ev_set;
    logic [hrp_pkg::EV_W-1:0] next_raw;
    always_comb begin
        ev_set                     = '0;
        ev_set[hrp_pkg::EV_MATCH0] = match_hit[0];                       // [RULE14]
        ev_set[hrp_pkg::EV_MATCH1] = match_hit[1];                       // [RULE14]
        ev_set[hrp_pkg::EV_FLAG_A] = flag_a_now;                         // [RULE8]
        ev_set[hrp_pkg::EV_WAKE]   = rise(wake_pin, wake_pin_q);
        next_raw = (raw_event_status & ~event_clear) | ev_set;           // [RULE22] [RULE25]
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            raw_event_status    <= '0;
            masked_event_status <= '0;
            irq                 <= 1'b0;
        end else if (clk_en) begin
            raw_event_status    <= next_raw;                             // [RULE19] [RULE21]
            masked_event_status <= next_raw & event_mask;                // [RULE21] [RULE24] [RULE25]
            irq                 <= |(next_raw & event_mask);             // [RULE20]
        end
    end

    // Retained words; no reset so contents ride through hibernation
    logic [hrp_pkg::WORD_W-1:0] mem [MEM_WORDS];
    always_ff @(posedge ref_clk) begin
        if (clk_en && mem_write) begin
            mem[mem_addr] <= mem_wdata;                                  // [RULE16]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            retained_words <= '0;
        end else if (clk_en) begin
            retained_words <= mem[mem_addr];                             // [RULE16]
        end
    end
endmodule

//--- verif/hibernate_rtc_power_control_test.sv
`timescale 1ns/1ps
module hibernate_rtc_power_control_test;
    logic        ref_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, xtal_in = 1'b0, press = 1'b0;
    logic        battery_low = 1'b0, counter_load_write = 1'b0, mem_write = 1'b0;
    logic [7:0]  main_control = 8'h00;
    logic [15:0] predivider_trim = 16'h7FFF;
    logic [31:0] match_value_0 = 32'h12345678, match_value_1 = 32'h9ABCDEF0;
    logic [31:0] counter_load = 32'h00000000, mem_wdata = 32'h00000000;
    logic [3:0]  event_mask = 4'h0, event_clear = 4'h0;
    logic [5:0]  mem_addr = 6'h00;
    logic [31:0] retained_words, counter_value;
    logic [3:0]  raw_event_status, masked_event_status;
    logic        irq, hibernated, sleep_refused, power_cut_n, osc_in, wake_n, vdd_on;
    int          num_errors = 0, n_checks = 0;
    always #25 ref_clk = ~ref_clk;
    hrp_top u_dut (
        .ref_clk, .resetn, .clk_en, .xtal_in, .osc_in, .wake_n, .battery_low, .main_control,
        .predivider_trim, .match_value_0, .match_value_1, .counter_load, .counter_load_write,
        .event_mask, .event_clear, .mem_write, .mem_addr, .mem_wdata, .retained_words,
        .counter_value, .raw_event_status, .masked_event_status, .irq, .hibernated,
        .sleep_refused, .power_cut_n
    );
    hrp_wake_model u_far (.ref_clk, .power_cut_n, .press, .osc_in, .wake_n, .vdd_on);
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wait_hi(input bit on_power, input string nm);
        logic s;
        s = 1'b0;
        for (int i = 0; i < 8; i++) begin
            tick(1);
            s = on_power ? power_cut_n : sleep_refused;
            if (s === 1'b1) break;
        end
        chk(nm, s, 1'b1);
        if (s !== 1'b1) finish_test();
    endtask
    task automatic ctl(input logic [7:0] v);
        @(posedge ref_clk);
        main_control <= v;
    endtask
    task automatic clr;
        @(posedge ref_clk);
        event_clear <= 4'hF;
        @(posedge ref_clk);
        event_clear <= 4'h0;
        tick(2);
    endtask
    task automatic load(input logic [31:0] v);
        @(posedge ref_clk);
        counter_load <= v;
        counter_load_write <= 1'b1;
        @(posedge ref_clk);
        counter_load_write <= 1'b0;
        tick(3);
    endtask
    function automatic logic [31:0] pat(input int i);
        return {i[7:0], ~i[7:0], 16'hC35A};
    endfunction
    task automatic rd(input int i);
        @(posedge ref_clk);
        mem_addr <= i[5:0];
        tick(1);
        chk("retained_words", retained_words, pat(i));
    endtask
    initial begin
        int i;
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        tick(3);
        chk("power_cut_n", power_cut_n, 1'b1);
        chk("raw_event_status", raw_event_status, 4'h0);
        chk("counter_value", counter_value, 32'h00000000);
        $display("reset test done");
        for (i = 0; i < 64; i++) begin
            @(posedge ref_clk);
            mem_write <= 1'b1;
            mem_addr  <= i[5:0];
            mem_wdata <= pat(i);
        end
        @(posedge ref_clk);
        mem_write <= 1'b0;
        for (i = 0; i < 64; i++) rd(i);
        $display("memory test done");
        for (i = 0; i < 2; i++) begin
            @(posedge ref_clk);
            event_mask <= 4'h1 << i;
            load(i ? 32'h9ABCDEF0 : 32'h12345678);
            chk("counter_value", counter_value, i ? 32'h9ABCDEF0 : 32'h12345678);
            chk("raw_event_status", raw_event_status, 32'h1 << i);
            chk("masked_event_status", masked_event_status, 32'h1 << i);
            chk("irq", irq, 1'b1);
            clr;
            chk("raw_event_status", raw_event_status, 4'h0);
            chk("irq", irq, 1'b0);
        end
        $display("match test done");
        @(posedge ref_clk);
        clk_en <= 1'b0;
        load(32'h0000ABCD);
        chk("counter_value", counter_value, 32'h9ABCDEF0);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        tick(2);
        $display("freeze test done");
        ctl(8'h40);
        ctl(8'h42);
        wait_hi(1'b0, "sleep_refused");
        chk("power_cut_n", power_cut_n, 1'b1);
        ctl(8'hF4);
        battery_low <= 1'b1;
        tick(5);
        chk("raw_event_status", raw_event_status[2], 1'b1);
        ctl(8'hF6);
        wait_hi(1'b0, "sleep_refused");
        chk("hibernated", hibernated, 1'b0);
        ctl(8'h74);
        battery_low <= 1'b0;
        tick(3);
        clr;
        chk("raw_event_status", raw_event_status, 4'h0);
        $display("battery test done");
        ctl(8'h76);
        tick(2);
        chk("power_cut_n", power_cut_n, 1'b0);
        chk("vdd_on", vdd_on, 1'b0);
        chk("hibernated", hibernated, 1'b1);
        @(posedge ref_clk);
        battery_low <= 1'b1;
        tick(6);
        chk("raw_event_status", raw_event_status, 4'h0);
        @(posedge ref_clk);
        press <= 1'b1;
        wait_hi(1'b1, "power_cut_n");
        chk("raw_event_status", raw_event_status[3], 1'b1);
        chk("vdd_on", vdd_on, 1'b1);
        rd(5);
        $display("pin wake test done");
        ctl(8'h48);
        press <= 1'b0;
        battery_low <= 1'b0;
        event_mask <= 4'h0;
        load(32'h00000100);
        clr;
        ctl(8'h4A);
        tick(2);
        chk("hibernated", hibernated, 1'b1);
        load(32'h12345678);
        wait_hi(1'b1, "power_cut_n");
        chk("raw_event_status", raw_event_status[0], 1'b1);
        chk("masked_event_status", masked_event_status, 4'h0);
        $display("match wake test done");
        ctl(8'h05);
        tick(300);
        chk("counter_value", counter_value, 32'h12345678);
        ctl(8'h45);
        for (i = 0; i < 70000 && counter_value === 32'h12345678; i++) tick(1);
        chk("counter_value", counter_value, 32'h12345679);
        chk("second_cycles", i > 65500 && i < 65560, 1'b1);
        $display("count test done");
        finish_test();
    end
endmodule

//--- verif/hrp_top_asserts.sv
`timescale 1ns/1ps
module hrp_top_asserts (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic        clk_en,
    // Watched inputs
    input wire logic        wake_n,
    input wire logic        battery_low,
    input wire logic [7:0]  main_control,
    input wire logic [31:0] counter_load,
    input wire logic        counter_load_write,
    input wire logic [3:0]  event_mask,
    input wire logic [3:0]  event_clear,
    // Watched outputs
    input wire logic [31:0] counter_value,
    input wire logic [3:0]  raw_event_status,
    input wire logic [3:0]  masked_event_status,
    input wire logic        irq,
    input wire logic        hibernated,
    input wire logic        sleep_refused,
    input wire logic        power_cut_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence s_req;
        $rose(main_control[1]) && clk_en && !hibernated;
    endsequence
    sequence s_low;
        battery_low && $past(battery_low) && $past(battery_low, 2) && $past(battery_low, 3);
    endsequence
    sleep_cut_a: assert property (
        s_req ##0 (main_control[4:3] != 2'h0 && !main_control[7]) |=> !power_cut_n)
        else $error("sleep request did not cut power");
    refuse_nowake_a: assert property (
        s_req ##0 (main_control[4:3] == 2'h0) |=> sleep_refused && power_cut_n)
        else $error("sleep without wake source not refused");
    refuse_flag_a_a: assert property (
        s_req ##0 (main_control[7] && main_control[5]) ##0 s_low |=> sleep_refused && power_cut_n)
        else $error("sleep on low battery not refused");
    pin_wake_a: assert property (
        hibernated && main_control[4] && clk_en && !wake_n && $past(wake_n) |-> ##[1:4] power_cut_n)
        else $error("wake pin did not restore power");
    cut_state_a: assert property (hibernated == !power_cut_n)
        else $error("hibernated and power cut disagree");
    mask_and_a: assert property (
        $stable(event_mask) |-> masked_event_status == (raw_event_status & event_mask))
        else $error("masked status not raw and mask");
    irq_or_a: assert property (irq == |masked_event_status)
        else $error("irq not the or of masked events");
    sticky_raw_a: assert property (
        ($past(raw_event_status) & ~$past(event_clear) & ~raw_event_status) == 4'h0)
        else $error("raw flag dropped without clear");
    load_value_a: assert property (
        counter_load_write && clk_en && !main_control[0] ##1 clk_en && !main_control[0]
        |=> counter_value == $past(counter_load, 2))
        else $error("counter load not seen");
endmodule
bind hrp_top hrp_top_asserts u_chk (
    .ref_clk, .resetn, .clk_en, .wake_n, .battery_low, .main_control, .counter_load,
    .counter_load_write, .event_mask, .event_clear, .counter_value, .raw_event_status,
    .masked_event_status, .irq, .hibernated, .sleep_refused, .power_cut_n
);

//--- verif/hrp_wake_model.sv
`timescale 1ns/1ps
module hrp_wake_model (
    // Board side
    input  wire logic ref_clk,
    input  wire logic power_cut_n,
    input  wire logic press,
    // Pins into the block
    output logic      osc_in,
    output logic      wake_n,
    output logic      vdd_on
);
    // Free running oscillator, sped up for run time, needs no settling
    always @(posedge ref_clk) osc_in <= (osc_in === 1'b1) ? 1'b0 : 1'b1;
    // Pull-up holds the pin high unless pressed
    assign wake_n = ~press;
    // Regulator on only while its enable is released
    assign vdd_on = power_cut_n;
endmodule
